// ### hw/fci_defines.svh
// Purpose: constants of the flash control interface
// Assumes: 125 MHz system clock
// Notes:   byte offsets on the register bus
`ifndef FCI_DEFINES_SVH
`define FCI_DEFINES_SVH
`define FCI_CLK_MHZ        125
`define FCI_ERASE_TIME_US  20000
`define FCI_PROG_TIME_US   50
`define FCI_ERASE_CYCLES   (`FCI_ERASE_TIME_US * `FCI_CLK_MHZ)
`define FCI_PROG_CYCLES    (`FCI_PROG_TIME_US * `FCI_CLK_MHZ)
`define FCI_SIG_CYCLES     32'h0000_0200
`define FCI_BLK_STRIDE     12'h040
`define FCI_OFF_STATUS     6'h00
`define FCI_OFF_MODE       6'h04
`define FCI_OFF_COMMAND    6'h08
`define FCI_OFF_DATA       6'h0C
`define FCI_OFF_ADDRESS    6'h10
`define FCI_OFF_SIGNATURE  6'h14
`define FCI_OFF_PROTECT    6'h18
`define FCI_OFF_KEY        6'h1C
`define FCI_ADDR_IRQ_STA   12'h080
`define FCI_ADDR_IRQ_MASK  12'h084
`define FCI_CMD_PROGRAM    8'h02
`define FCI_CMD_ERASE      8'h05
`define FCI_CMD_SIGNATURE  8'h06
`define FCI_MODE_CMD_EN    0
`define FCI_STA_BUSY       0
`define FCI_STA_DONE       1
`define FCI_STA_ERR        2
`define FCI_KERNEL_BASE    16'h7800
`define FCI_BLK0_BASE      32'h0009_0000
`define FCI_BLK0_LAST      32'h0009_7FFF
`define FCI_BLK1_BASE      32'h0008_0000
`define FCI_BLK1_LAST      32'h0008_FFFF
`define FCI_PROT_OPEN      32'hFFFF_FFFF
`endif

// ### hw/fci_pkg.sv
// Purpose: types of the flash control interface
// Assumes: constants live in fci_defines.svh
// Notes:   one sequencer state per block
package fci_pkg;
  typedef enum logic [1:0] {
    FCI_IDLE,
    FCI_RUN
  } fci_seq_type;
endpackage

// ### hw/fci_top.sv
// Purpose: register front end and command sequencer for two flash blocks
// Assumes: apb slave, 125 MHz clk_sys, async active-low rst_b
// Notes:   block 0 at byte 0x000, block 1 at 0x040, interrupt regs at 0x080
//
// Summary of operation
// - block 0 is 32 kB at 0x90000-0x97FFF, top 2 kB kernel area.
// - block 1 is separate 64 kB at 0x80000-0x8FFFF, independent control.
// - fetches from the idle block never stall while other block busy.
// - fetch to a busy block stalls the core until its command finishes.
// - status register is read only; writes do nothing.
// - each block has a mode register steering its command interface.
// - 8-bit command register; a write starts the coded operation.
// - 16-bit data register holds halfword to program or command result.
// - 16-bit address register selects location or page for next command.
// - signature command leaves a 24-bit code signature in signature register.
// - protection gates access; a configured shadow requires a key for changes.
// - every reset copies the protection shadow into the live protection register.
// - this register interface is the only path for all programming.
// - erase acts on whole 512-byte pages and takes 20 ms.
// - programming accepts only aligned 16-bit halfwords.
`timescale 1ns/1ps
`include "fci_defines.svh"

////////////////////////////////////////////////////////////////////////////
// register map, byte offsets, one 32-bit word per register
// block b sits at b * 0x040; narrow registers use the low bits
//   +0x00 status: bit0 busy, bit1 done, bit2 error; read clears the done and error bits it showed
//   +0x04 mode: bit0 enables commands
//   +0x08 command: write starts program, page erase or signature
//   +0x0C data: halfword to program, or command result
//   +0x10 address: location or page of the next command
//   +0x14 signature: read only, result of the signature command
//   +0x18 protection: one enable bit per 1/32 of the block, 0 protects
//   +0x1C key: write the key before changing protection, reads key state
// 0x080 interrupt status: done and error per block, read clears
// 0x084 interrupt mask: same layout as interrupt status
// any other word answers with pslverr
//
// bus timing: setup edge latches read data, access edge commits writes;
// pready stands for the one access cycle, so there are no wait states
//
// hazards worth knowing:
// - a flag may be set between setup and access of a status read; only the
//   bits that the read returned are cleared, so a late event is not lost
// - writes to a busy block are dropped without error; poll busy first
// - the command counter is loaded on the access edge of the command write
//   and runs down to zero, so busy lasts exactly the programmed cycle count
// - core stall follows the fetch by one clock, from the registered decode
// - protection reload takes one clock after reset; read it from then on
// - the signature folds in the halfwords programmed since the last erase
// - erase and program counts are parameters so a bench can shorten them
// - the key is armed by one write and spent by the next protection write

module fci_top #(
  parameter int unsigned ERASE_CYCLES = `FCI_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES  = `FCI_PROG_CYCLES,
  parameter logic [31:0] KEY_VALUE    = 32'h5A5A_C3C3  // arbitrary value
) (
  input  wire logic        clk_sys,           // system clock
  input  wire logic        rst_b,             // async reset, active low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb enable
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error, unmapped address
  input  wire logic        core_fetch_valid,  // core fetch request
  input  wire logic [31:0] core_fetch_addr,   // core fetch address
  input  wire logic [31:0] prot_shadow0,      // nonvolatile shadow, block 0
  input  wire logic [31:0] prot_shadow1,      // nonvolatile shadow, block 1
  output logic             core_stall,        // core halted on busy block
  output logic             irq                // level interrupt
);

  // all state of the block in one word; one comb process fills nxt_st
  // and one clocked process registers it, so no field has two drivers
  typedef struct packed {
    fci_pkg::fci_seq_type [1:0]       seq;
    logic                 [1:0][31:0] cnt;
    logic                 [1:0][7:0]  cmd;
    logic                 [1:0][7:0]  mode;
    logic                 [1:0][15:0] data;
    logic                 [1:0][15:0] addr;
    logic                 [1:0][23:0] sig;
    logic                 [1:0][23:0] sig_acc;
    logic                 [1:0][31:0] prot;
    logic                 [1:0]       key_ok;
    logic                 [1:0]       done;
    logic                 [1:0]       err;
    logic                 [3:0]       irq_sta;
    logic                 [3:0]       irq_mask;
    logic                             reload;
    logic                 [31:0]      prdata;
    logic                             pready;
    logic                             pslverr;
    logic                             stall;
    logic                             irq;
  } fci_state_type;

  // registered state and its next value
  fci_state_type st_ff;
  fci_state_type nxt_st;

  logic        setup_phase;
  logic        acc_wr;
  logic        acc_rd;
  logic        in_blk_space;
  logic        blk_sel;
  logic [5:0]  blk_off;
  logic [31:0] shadow [2];

  // bus phases and block address decode
  assign setup_phase  = psel & ~penable;
  assign acc_wr       = psel & penable & st_ff.pready & pwrite;
  assign acc_rd       = psel & penable & st_ff.pready & ~pwrite;
  assign in_blk_space = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'b00);
  assign blk_sel      = paddr[6];
  assign blk_off      = paddr[5:0];
  assign shadow[0]    = prot_shadow0;
  assign shadow[1]    = prot_shadow1;

  ////////////////////////////////////////////////////////////////////////////
  // command checks

  // protection slice of a location, one of 32 per block
  // block 0 has 1 kB slices, block 1 has 2 kB slices
  function automatic logic [4:0] prot_slice(input logic blk, input logic [15:0] a);
    prot_slice = blk ? a[15:11] : a[14:10];
  endfunction

  // a command may start only if known, enabled and unprotected; program must be aligned, program and erase outside kernel
  function automatic logic cmd_ok(input logic blk, input logic [7:0] c, input logic [7:0] m,
                                  input logic [15:0] a, input logic [31:0] p);
    logic known;
    logic in_kernel;
    known     = (c == `FCI_CMD_PROGRAM) || (c == `FCI_CMD_ERASE) || (c == `FCI_CMD_SIGNATURE);
    in_kernel = ~blk && (a >= `FCI_KERNEL_BASE);
    cmd_ok    = known && m[`FCI_MODE_CMD_EN] && p[prot_slice(blk, a)];
    if ((c == `FCI_CMD_PROGRAM) && a[0]) begin
      cmd_ok = 1'b0;
    end
    // signature may still cover the kernel; program and erase may not
    if ((c != `FCI_CMD_SIGNATURE) && in_kernel) begin
      cmd_ok = 1'b0;
    end
    // block 0 holds 32 kB only
    if (~blk && a[15]) begin
      cmd_ok = 1'b0;
    end
  endfunction

  // run length of an accepted command, counted down to zero
  // the cycle in which the counter reads zero is the last busy cycle
  function automatic logic [31:0] cmd_len(input logic [7:0] c);
    if (c == `FCI_CMD_ERASE) begin
      cmd_len = ERASE_CYCLES - 32'h0000_0001;
    end else if (c == `FCI_CMD_PROGRAM) begin
      cmd_len = PROG_CYCLES - 32'h0000_0001;
    end else begin
      cmd_len = `FCI_SIG_CYCLES - 32'h0000_0001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic hit;
    logic [31:0] rd_val;
    logic blk_wr;
    logic blk_rd;
    logic [1:0] busy;
    logic in0;
    logic in1;
    hit    = 1'b0;
    rd_val = 32'h0000_0000;
    blk_wr = 1'b0;
    blk_rd = 1'b0;
    busy   = 2'b00;
    in0    = 1'b0;
    in1    = 1'b0;
    nxt_st = st_ff;

    // read decode during setup, answered in the access phase
    if (in_blk_space) begin
      hit = 1'b1;
      if (blk_off == `FCI_OFF_STATUS) begin
        rd_val = {29'h0000_0000, st_ff.err[blk_sel], st_ff.done[blk_sel],
                  st_ff.seq[blk_sel] == fci_pkg::FCI_RUN};
      end else if (blk_off == `FCI_OFF_MODE) begin
        rd_val = {24'h00_0000, st_ff.mode[blk_sel]};
      end else if (blk_off == `FCI_OFF_COMMAND) begin
        rd_val = {24'h00_0000, st_ff.cmd[blk_sel]};
      end else if (blk_off == `FCI_OFF_DATA) begin
        rd_val = {16'h0000, st_ff.data[blk_sel]};
      end else if (blk_off == `FCI_OFF_ADDRESS) begin
        rd_val = {16'h0000, st_ff.addr[blk_sel]};
      end else if (blk_off == `FCI_OFF_SIGNATURE) begin
        rd_val = {8'h00, st_ff.sig[blk_sel]};
      end else if (blk_off == `FCI_OFF_PROTECT) begin
        rd_val = st_ff.prot[blk_sel];
      end else if (blk_off == `FCI_OFF_KEY) begin
        rd_val = {31'h0000_0000, st_ff.key_ok[blk_sel]};
      end else begin
        hit = 1'b0;
      end
    end else if (paddr == `FCI_ADDR_IRQ_STA) begin
      hit    = 1'b1;
      rd_val = {28'h000_0000, st_ff.irq_sta};
    end else if (paddr == `FCI_ADDR_IRQ_MASK) begin
      hit    = 1'b1;
      rd_val = {28'h000_0000, st_ff.irq_mask};
    end

    // single apb register path, zero wait states
    // pready is raised by the setup cycle alone, so every access takes one cycle
    // unmapped words answer with pslverr and read as zero
    nxt_st.pready  = setup_phase;
    nxt_st.pslverr = setup_phase & ~hit;
    nxt_st.prdata  = (setup_phase & ~pwrite & hit) ? rd_val : 32'h0000_0000;

    // interrupt status clears on read, events below win
    // only bits returned by this read are cleared; a bit set after the
    // setup edge was not seen by software and must survive the access
    if (acc_rd && (paddr == `FCI_ADDR_IRQ_STA)) begin
      nxt_st.irq_sta = st_ff.irq_sta & ~st_ff.prdata[3:0];
    end
    if (acc_wr && (paddr == `FCI_ADDR_IRQ_MASK)) begin
      nxt_st.irq_mask = pwdata[3:0];
    end

    // shadow loaded into live protection after every reset
    if (st_ff.reload) begin
      nxt_st.reload  = 1'b0;
      nxt_st.prot[0] = shadow[0];
      nxt_st.prot[1] = shadow[1];
    end

    // per-block registers and sequencers, fully independent
    for (int b = 0; b < 2; b++) begin
      blk_wr = acc_wr && in_blk_space && (blk_sel == b[0]);
      blk_rd = acc_rd && in_blk_space && (blk_sel == b[0]);

      // done and error clear on status read, set wins
      // prdata still holds the word latched at setup; clear only what it showed
      if (blk_rd && (blk_off == `FCI_OFF_STATUS)) begin
        if (st_ff.prdata[`FCI_STA_DONE]) begin
          nxt_st.done[b] = 1'b0;
        end
        if (st_ff.prdata[`FCI_STA_ERR]) begin
          nxt_st.err[b] = 1'b0;
        end
      end

      // status offset has no write path
      // writes to a busy block are dropped; software polls busy first
      if (blk_wr && (st_ff.seq[b] == fci_pkg::FCI_IDLE)) begin
        if (blk_off == `FCI_OFF_MODE) begin
          nxt_st.mode[b] = pwdata[7:0];
        end else if (blk_off == `FCI_OFF_DATA) begin
          nxt_st.data[b] = pwdata[15:0];
        end else if (blk_off == `FCI_OFF_ADDRESS) begin
          nxt_st.addr[b] = pwdata[15:0];
        end else if (blk_off == `FCI_OFF_KEY) begin
          nxt_st.key_ok[b] = (pwdata == KEY_VALUE);
        end else if (blk_off == `FCI_OFF_PROTECT) begin
          if ((shadow[b] == `FCI_PROT_OPEN) || st_ff.key_ok[b]) begin
            nxt_st.prot[b] = pwdata;
          end else begin
            nxt_st.err[b] = 1'b1;
          end
          nxt_st.key_ok[b] = 1'b0;
        end else if (blk_off == `FCI_OFF_COMMAND) begin
          nxt_st.cmd[b] = pwdata[7:0];
          if (cmd_ok(b[0], pwdata[7:0], st_ff.mode[b], st_ff.addr[b], st_ff.prot[b])) begin
            nxt_st.seq[b] = fci_pkg::FCI_RUN;
            nxt_st.cnt[b] = cmd_len(pwdata[7:0]);
          end else begin
            // refused: error flag and error interrupt, no busy
            nxt_st.err[b]         = 1'b1;
            nxt_st.irq_sta[2 * b + 1] = 1'b1;
          end
        end
      end

      // command sequencer
      case (st_ff.seq[b])
        fci_pkg::FCI_IDLE: begin
          // counter untouched here, a command write above may have loaded it
          busy[b] = 1'b0;
        end
        fci_pkg::FCI_RUN: begin
          busy[b] = 1'b1;
          if (st_ff.cnt[b] == 32'h0000_0000) begin
            nxt_st.seq[b]         = fci_pkg::FCI_IDLE;
            nxt_st.done[b]        = 1'b1;
            nxt_st.irq_sta[2 * b] = 1'b1;
            if (st_ff.cmd[b] == `FCI_CMD_PROGRAM) begin
              nxt_st.sig_acc[b] = {st_ff.sig_acc[b][22:0], st_ff.sig_acc[b][23]}
                                  ^ {8'h00, st_ff.data[b]};
            end else if (st_ff.cmd[b] == `FCI_CMD_ERASE) begin
              // whole 512-byte page erased, page base returned
              nxt_st.sig_acc[b] = 24'h00_0000;
              nxt_st.data[b]    = {st_ff.addr[b][15:9], 9'h000};
            end else begin
              nxt_st.sig[b]  = st_ff.sig_acc[b] ^ {8'h00, st_ff.addr[b]};
              nxt_st.data[b] = st_ff.sig_acc[b][15:0];
            end
          end else begin
            nxt_st.cnt[b] = st_ff.cnt[b] - 32'h0000_0001;
          end
        end
        default: begin
          nxt_st.seq[b] = fci_pkg::FCI_IDLE;
        end
      endcase
    end

    in0 = (core_fetch_addr >= `FCI_BLK0_BASE) && (core_fetch_addr <= `FCI_BLK0_LAST);
    in1 = (core_fetch_addr >= `FCI_BLK1_BASE) && (core_fetch_addr <= `FCI_BLK1_LAST);
    // stall only on the busy block
    // a fetch outside both windows never stalls
    nxt_st.stall = core_fetch_valid && ((in0 && busy[0]) || (in1 && busy[1]));
    // level interrupt from the next flags, so it follows the same edge
    nxt_st.irq   = |(nxt_st.irq_sta & nxt_st.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset opens protection and arms the reload flag; the first clock after
  // release copies the shadow words in, so protection is only valid from then
  // the reset branch assigns constants only, the shadow is never read in it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff          <= '0;
      st_ff.seq[0]   <= fci_pkg::FCI_IDLE;
      st_ff.seq[1]   <= fci_pkg::FCI_IDLE;
      st_ff.prot[0]  <= `FCI_PROT_OPEN;
      st_ff.prot[1]  <= `FCI_PROT_OPEN;
      st_ff.reload   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata     = st_ff.prdata;
  assign pready     = st_ff.pready;
  assign pslverr    = st_ff.pslverr;
  assign core_stall = st_ff.stall;
  assign irq        = st_ff.irq;

endmodule

// ### sim/fci_top_props.sv
// Purpose: port-level checks of the flash control front end
// Assumes: one clock domain, async active-low reset
// Notes:   bound into every fci_top instance
`timescale 1ns/1ps
module fci_top_props (
  input wire logic        clk_sys,          // system clock
  input wire logic        rst_b,            // reset, active low
  input wire logic        psel,             // apb select
  input wire logic        penable,          // apb enable
  input wire logic        pwrite,           // apb direction
  input wire logic [11:0] paddr,            // apb address
  input wire logic [31:0] pwdata,           // apb write data
  input wire logic [31:0] prdata,           // apb read data
  input wire logic        pready,           // apb ready
  input wire logic        pslverr,          // apb error
  input wire logic        core_fetch_valid, // fetch request
  input wire logic [31:0] core_fetch_addr,  // fetch address
  input wire logic [31:0] prot_shadow0,     // shadow block 0
  input wire logic [31:0] prot_shadow1,     // shadow block 1
  input wire logic        core_stall,       // core halted
  input wire logic        irq               // interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // helper decodes of the request
  wire logic in_win = core_fetch_valid && core_fetch_addr >= 32'h0008_0000 && core_fetch_addr <= 32'h0009_7FFF;
  wire logic rd_blk = pready && !pwrite && paddr[11:7] == 5'h00;
  wire logic mapped = paddr[11:7] == 5'h00 && paddr[5:0] <= 6'h1C && paddr[1:0] == 2'h0;
  ////////////////////////////////////////////////////////////////////////
  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_no_err_mapped; pready && mapped |-> !pslverr; endproperty
  property p_idle_zero; !pready |-> prdata == 32'h0000_0000; endproperty
  property p_cmd_width; rd_blk && paddr[5:0] == 6'h08 |-> prdata[31:8] == 24'h00_0000; endproperty
  property p_data_width; rd_blk && paddr[5:0] == 6'h0C |-> prdata[31:16] == 16'h0000; endproperty
  property p_addr_width; rd_blk && paddr[5:0] == 6'h10 |-> prdata[31:16] == 16'h0000; endproperty
  property p_sig_width; rd_blk && paddr[5:0] == 6'h14 |-> prdata[31:24] == 8'h00; endproperty
  property p_stall_cause; core_stall |-> $past(in_win); endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_no_err_mapped: assert property (p_no_err_mapped) else $error("error on mapped register");
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
  a_cmd_width: assert property (p_cmd_width) else $error("command wider than 8 bits");
  a_data_width: assert property (p_data_width) else $error("data wider than 16 bits");
  a_addr_width: assert property (p_addr_width) else $error("address wider than 16 bits");
  a_sig_width: assert property (p_sig_width) else $error("signature wider than 24 bits");
  a_stall_cause: assert property (p_stall_cause) else $error("stall without window fetch");
  c_stall: cover property (core_stall);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind fci_top fci_top_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_fetch_valid(core_fetch_valid), .core_fetch_addr(core_fetch_addr), .prot_shadow0(prot_shadow0),
  .prot_shadow1(prot_shadow1), .core_stall(core_stall), .irq(irq));

// ### sim/fci_core_model.sv
// Purpose: core fetch side and protection shadow source
// Assumes: fetch request held two edges before stall is looked at
// Notes:   released address shows the inverse of the last one
`timescale 1ns/1ps
module fci_core_model #(
  parameter logic [31:0] SHADOW0 = 32'hFFFF_FFFF,
  parameter logic [31:0] SHADOW1 = 32'h0000_FFFF
) (
  input  wire logic        clk_sys,          // system clock
  input  wire logic        core_stall,       // stall from controller
  output logic             core_fetch_valid, // fetch request
  output logic      [31:0] core_fetch_addr,  // fetch address
  output logic      [31:0] prot_shadow0,     // shadow block 0
  output logic      [31:0] prot_shadow1      // shadow block 1
);
  initial begin
    core_fetch_valid = 1'b0;
    core_fetch_addr = 32'h0000_0000;
    prot_shadow0 = SHADOW0;
    prot_shadow1 = SHADOW1;
  end
  task automatic fetch(input logic [31:0] a, output logic s);
    @(posedge clk_sys);
    core_fetch_valid <= 1'b1;
    core_fetch_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 s = core_stall;
    @(posedge clk_sys);
    core_fetch_valid <= 1'b0;
    core_fetch_addr <= ~a;
  endtask
endmodule

// ### sim/tb_top.sv
// Purpose: register-level tests of the flash control front end
// Assumes: short erase and program counts
// Notes:   apb master tasks, one transfer at a time
`timescale 1ns/1ps
`include "fci_defines.svh"
module tb_top;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, fv, stall, irq, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fa, sh0, sh1, r;
  int n_mismatch, compares;
  fci_top #(.ERASE_CYCLES(20), .PROG_CYCLES(8)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_fetch_valid(fv), .core_fetch_addr(fa), .prot_shadow0(sh0),
    .prot_shadow1(sh1), .core_stall(stall), .irq(irq));
  fci_core_model u_core (.clk_sys(clk_sys), .core_stall(stall), .core_fetch_valid(fv),
    .core_fetch_addr(fa), .prot_shadow0(sh0), .prot_shadow1(sh1));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, e, r);
  endtask
  task automatic wait_idle(input logic [11:0] a, input logic [31:0] e);
    for (int i = 0; i < 1000; i++) begin
      xfer(1'b0, a, 32'h0000_0000);
      if (r[0] !== 1'b1) break;
    end
    chk("status", e, r);
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd("prot0", 12'h018, 32'hFFFF_FFFF);
    rd("prot1", 12'h058, 32'h0000_FFFF);
    xfer(1'b1, 12'h004, 32'h0000_0001);
    xfer(1'b1, 12'h044, 32'h0000_0001);
    rd("mode", 12'h004, 32'h0000_0001);
    xfer(1'b1, 12'h058, 32'h0001_FFFF);
    rd("prot1", 12'h058, 32'h0000_FFFF);
    rd("status1", 12'h040, 32'h0000_0004);
    xfer(1'b1, 12'h05C, 32'h5A5A_C3C3);
    rd("key1", 12'h05C, 32'h0000_0001);
    xfer(1'b1, 12'h058, 32'h0001_FFFF);
    rd("prot1", 12'h058, 32'h0001_FFFF);
    xfer(1'b1, 12'h040, 32'hFFFF_FFFF);
    rd("status1", 12'h040, 32'h0000_0000);
    xfer(1'b1, 12'h050, 32'h0000_0234);
    xfer(1'b1, 12'h048, {24'h00_0000, `FCI_CMD_ERASE});
    rd("status1", 12'h040, 32'h0000_0001);
    u_core.fetch(32'h0009_0010, s);
    chk("stall", 32'h0, {31'h0, s});
    u_core.fetch(32'h0008_0100, s);
    chk("stall", 32'h1, {31'h0, s});
    wait_idle(12'h040, 32'h0000_0002);
    rd("data1", 12'h04C, 32'h0000_0200);
    rd("cmd1", 12'h048, 32'h0000_0005);
    rd("addr1", 12'h050, 32'h0000_0234);
    #1 chk("irq", 32'h0, {31'h0, irq});
    xfer(1'b1, 12'h084, 32'h0000_000F);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd("irqsta", 12'h080, 32'h0000_0004);
    #1 chk("irq", 32'h0, {31'h0, irq});
    xfer(1'b1, 12'h00C, 32'h0000_1234);
    xfer(1'b1, 12'h010, 32'h0000_0100);
    xfer(1'b1, 12'h008, {24'h00_0000, `FCI_CMD_PROGRAM});
    wait_idle(12'h000, 32'h0000_0002);
    xfer(1'b1, 12'h008, {24'h00_0000, `FCI_CMD_SIGNATURE});
    wait_idle(12'h000, 32'h0000_0002);
    rd("sig0", 12'h014, 32'h0000_1334);
    rd("data0", 12'h00C, 32'h0000_1234);
    xfer(1'b1, 12'h010, 32'h0000_7800);
    xfer(1'b1, 12'h008, {24'h00_0000, `FCI_CMD_PROGRAM});
    rd("status0", 12'h000, 32'h0000_0004);
    xfer(1'b1, 12'h010, 32'h0000_0101);
    xfer(1'b1, 12'h008, {24'h00_0000, `FCI_CMD_PROGRAM});
    rd("status0", 12'h000, 32'h0000_0004);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd("irqsta", 12'h080, 32'h0000_0003);
    xfer(1'b1, 12'h004, 32'h0000_0000);
    xfer(1'b1, 12'h008, {24'h00_0000, `FCI_CMD_SIGNATURE});
    rd("status0", 12'h000, 32'h0000_0004);
    xfer(1'b0, 12'h0C0, 32'h0000_0000);
    chk("pslverr", 32'h1, {31'h0, s});
    // all commands finished before the reset pulse
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd("prot1", 12'h058, 32'h0000_FFFF);
    end_of_test();
  end
  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule
